//--- hw/tphcap_regs.sv
`include "tphcap_defs.svh"

module tphcap_regs
  import tphcap_pkg::*;
#(
  parameter int ENTRIES = 8
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // configuration access
  input wire tphcap_req_t i_req,
  output logic [31:0] o_rdata,
  output logic o_rvalid,
  // request engine view
  input wire logic [2:0] i_tag_index,
  output tphcap_hint_t o_hint
);

  // the register map has exactly two entries per table word
  if (ENTRIES != 2 * `TPHCAP_TBL_WORDS) begin : g_bad_entries
    $error("ENTRIES must match the table word count");
  end

  typedef struct packed {
    logic [2:0] mode;
    logic [1:0] en;
    logic [ENTRIES-1:0][7:0] tbl;
    logic [31:0] rdata;
    logic rvalid;
  } tphcap_state_t;

  tphcap_state_t st_q;
  tphcap_state_t st_d;

  logic [31:0] hdr_word;
  logic [31:0] cap_word;
  logic [31:0] ctl_word;
  logic [31:0] tbl_word [`TPHCAP_TBL_WORDS];
  logic [`TPHCAP_TBL_WORDS-1:0] tbl_hit;
  // any address this block answers; everything else reads zero and drops writes
  logic addr_mapped;

  assign addr_mapped = (i_req.addr == `TPHCAP_OFF_HDR) || (i_req.addr == `TPHCAP_OFF_CAP)
    || (i_req.addr == `TPHCAP_OFF_CTL) || (|tbl_hit);

  always_comb begin
    hdr_word = {`TPHCAP_NEXT_PTR, `TPHCAP_VERSION, `TPHCAP_EXT_ID};
    cap_word = 32'h0;
    cap_word[`TPHCAP_NO_ST_BIT] = 1'b1;
    cap_word[`TPHCAP_INTVEC_BIT] = 1'b0;
    cap_word[`TPHCAP_DEVSPEC_BIT] = 1'b1;
    cap_word[`TPHCAP_EXT_BIT] = 1'b0;
    cap_word[`TPHCAP_LOC_LSB +: 2] = `TPHCAP_LOC_IN_CAP;
    cap_word[`TPHCAP_SIZE_LSB +: 11] = `TPHCAP_TABLE_SIZE_M1;
    ctl_word = 32'h0;
    ctl_word[`TPHCAP_MODE_LSB +: 3] = st_q.mode;
    ctl_word[`TPHCAP_EN_LSB +: 2] = st_q.en;
  end

  // upper byte of each entry is hard zero
  genvar gw;
  generate
    for (gw = 0; gw < `TPHCAP_TBL_WORDS; gw++) begin : g_word
      assign tbl_word[gw] = {8'h00, st_q.tbl[2*gw+1], 8'h00, st_q.tbl[2*gw]};
      assign tbl_hit[gw] = (i_req.addr == 12'(`TPHCAP_OFF_TBL + 4 * gw));

      a_tbl_lo_entry: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_req.wr && tbl_hit[gw] && i_req.be[0] |=> st_q.tbl[2*gw] == $past(i_req.wdata[7:0]))
        else $error("lower table entry not written");

      a_tbl_hi_entry: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_req.wr && tbl_hit[gw] && i_req.be[2]
        |=> st_q.tbl[2*gw+1] == $past(i_req.wdata[23:16]))
        else $error("upper table entry not written");

      a_tbl_lo_keep: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_req.wr && tbl_hit[gw] && !i_req.be[0] |=> $stable(st_q.tbl[2*gw]))
        else $error("lower entry changed without its byte lane");

      a_tbl_hi_keep: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_req.wr && tbl_hit[gw] && !i_req.be[2] |=> $stable(st_q.tbl[2*gw+1]))
        else $error("upper entry changed without its byte lane");

      a_tbl_rd_word: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
        i_req.rd && tbl_hit[gw]
        |=> o_rdata == {8'h00, $past(st_q.tbl[2*gw+1]), 8'h00, $past(st_q.tbl[2*gw])})
        else $error("table word readback wrong");
    end
  endgenerate

  always_comb begin
    st_d = st_q;
    st_d.rvalid = i_req.rd;
    if (i_req.rd) begin
      if (i_req.addr == `TPHCAP_OFF_HDR) begin
        st_d.rdata = hdr_word;
      end else if (i_req.addr == `TPHCAP_OFF_CAP) begin
        st_d.rdata = cap_word;
      end else if (i_req.addr == `TPHCAP_OFF_CTL) begin
        st_d.rdata = ctl_word;
      end else begin
        st_d.rdata = 32'h0;
        for (int w = 0; w < `TPHCAP_TBL_WORDS; w++) begin
          if (tbl_hit[w]) begin
            st_d.rdata = tbl_word[w];
          end
        end
      end
    end
    // only the writable fields are touched; all else keeps its fixed value
    if (i_req.wr) begin
      if (i_req.addr == `TPHCAP_OFF_CTL) begin
        if (i_req.be[0]) begin
          st_d.mode = i_req.wdata[`TPHCAP_MODE_LSB +: 3];
        end
        if (i_req.be[1]) begin
          st_d.en = i_req.wdata[`TPHCAP_EN_LSB +: 2];
        end
      end
      for (int w = 0; w < `TPHCAP_TBL_WORDS; w++) begin
        if (tbl_hit[w]) begin
          if (i_req.be[0]) begin
            st_d.tbl[2*w] = i_req.wdata[`TPHCAP_ENT_LO_LSB +: 8];
          end
          if (i_req.be[2]) begin
            st_d.tbl[2*w+1] = i_req.wdata[`TPHCAP_ENT_HI_LSB +: 8];
          end
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_rdata = st_q.rdata;
  assign o_rvalid = st_q.rvalid;

  // hint view: reserved enable 10b is treated as off, prefix never allowed
  always_comb begin
    o_hint.mode = st_q.mode;
    o_hint.hint_enable = (st_q.en == TPHCAP_EN_TPH) || (st_q.en == TPHCAP_EN_TPH_EXT);
    o_hint.ext_enable = 1'b0;
    o_hint.tag = st_q.tbl[i_tag_index];
    o_hint.tag_valid = (st_q.tbl[i_tag_index] != 8'h00) && (st_q.mode == TPHCAP_MODE_DEV_SPEC);
  end

  // fixed words: header and capabilities never depend on state
  a_hdr_read: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_req.rd && i_req.addr == `TPHCAP_OFF_HDR |=> o_rvalid && o_rdata == 32'h01c1_0017)
    else $error("header read wrong");

  a_hdr_ver: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_req.rd && i_req.addr == `TPHCAP_OFF_HDR |=> o_rdata[19:16] == 4'h1)
    else $error("header version wrong");

  a_ptr_read: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_req.rd && i_req.addr == `TPHCAP_OFF_HDR |=> o_rdata[31:20] == 12'h01c)
    else $error("next pointer wrong");

  a_cap_read: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_req.rd && i_req.addr == `TPHCAP_OFF_CAP |=> o_rdata == 32'h0007_0205)
    else $error("capabilities word wrong");

  a_cap_bits: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_req.rd && i_req.addr == `TPHCAP_OFF_CAP |=> !o_rdata[1] && !o_rdata[8])
    else $error("unsupported mode advertised");

  a_cap_loc: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_req.rd && i_req.addr == `TPHCAP_OFF_CAP |=> o_rdata[2] && o_rdata[10:9] == 2'h1)
    else $error("table location or mode wrong");

  a_size_read: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_req.rd && i_req.addr == `TPHCAP_OFF_CAP |=> o_rdata[26:16] == 11'h007)
    else $error("table size wrong");

  a_cap_rsvd: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_req.rd && i_req.addr == `TPHCAP_OFF_CAP
    |=> o_rdata[7:3] == 5'h00 && o_rdata[15:11] == 5'h00 && o_rdata[31:27] == 5'h00)
    else $error("capabilities reserved bits set");

  // control word: only mode and enable are held
  a_ctl_write: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_req.wr && !i_req.rd && i_req.addr == `TPHCAP_OFF_CTL && i_req.be[1:0] == 2'h3
    ##1 !i_req.wr
    ##1 i_req.rd && !i_req.wr && i_req.addr == `TPHCAP_OFF_CTL
    |=> o_rdata == {22'h0, $past(i_req.wdata[9:8], 3), 5'h0, $past(i_req.wdata[2:0], 3)})
    else $error("control readback wrong");

  a_ctl_rsvd: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_req.rd && i_req.addr == `TPHCAP_OFF_CTL |=> o_rdata[31:10] == 22'h0 && o_rdata[7:3] == 5'h0)
    else $error("control reserved bits set");

  a_mode_keep: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_req.wr && i_req.addr == `TPHCAP_OFF_CTL && !i_req.be[0] |=> $stable(st_q.mode))
    else $error("mode changed without its byte lane");

  a_en_keep: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_req.wr && i_req.addr == `TPHCAP_OFF_CTL && !i_req.be[1] |=> $stable(st_q.en))
    else $error("enable changed without its byte lane");

  // hint view handed to the request engine
  a_no_prefix: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !o_hint.ext_enable)
    else $error("extended prefix enabled");

  a_off_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    st_q.en == TPHCAP_EN_OFF |-> !o_hint.hint_enable)
    else $error("hints enabled while off");

  a_rsvd_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    st_q.en == TPHCAP_EN_RSVD |-> !o_hint.hint_enable)
    else $error("hints enabled by reserved code");

  a_en_allows: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    st_q.en == TPHCAP_EN_TPH || st_q.en == TPHCAP_EN_TPH_EXT |-> o_hint.hint_enable)
    else $error("hints blocked while enabled");

  a_hint_mode: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_hint.mode == st_q.mode)
    else $error("hint mode differs from control");

  a_zero_tag: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_hint.tag == 8'h00 |-> !o_hint.tag_valid)
    else $error("zero tag marked valid");

  a_tag_usable: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_hint.tag != 8'h00 && st_q.mode == TPHCAP_MODE_DEV_SPEC |-> o_hint.tag_valid)
    else $error("usable tag marked invalid");

  a_tag_dev_only: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    st_q.mode != TPHCAP_MODE_DEV_SPEC |-> !o_hint.tag_valid)
    else $error("tag valid outside device mode");

  // table words
  a_tbl_upper: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_req.rd && i_req.addr >= `TPHCAP_OFF_TBL && i_req.addr < 12'h1bc
    |=> o_rdata[15:8] == 8'h00 && o_rdata[31:24] == 8'h00)
    else $error("table upper byte not zero");

  a_tbl_write: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_req.wr && i_req.addr == `TPHCAP_OFF_TBL && i_req.be[0]
    |=> st_q.tbl[0] == $past(i_req.wdata[7:0]))
    else $error("table entry not written");

  // read-only, unmapped and idle cycles leave state alone
  a_hdr_fixed: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_req.wr && i_req.addr == `TPHCAP_OFF_HDR |=> $stable(st_q.mode) && $stable(st_q.tbl))
    else $error("read-only write changed state");

  a_cap_fixed: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_req.wr && i_req.addr == `TPHCAP_OFF_CAP
    |=> $stable(st_q.mode) && $stable(st_q.en) && $stable(st_q.tbl))
    else $error("capabilities write changed state");

  a_unmapped_wr: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_req.wr && !addr_mapped |=> $stable(st_q.mode) && $stable(st_q.en) && $stable(st_q.tbl))
    else $error("unmapped write changed state");

  a_unmapped_rd: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_req.rd && !addr_mapped |=> o_rdata == 32'h0)
    else $error("unmapped read not zero");

  a_idle_keep: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !i_req.wr |=> $stable(st_q.mode) && $stable(st_q.en) && $stable(st_q.tbl))
    else $error("state changed without a write");

  // read answer timing
  a_rvalid_pulse: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    1'b1 |=> o_rvalid == $past(i_req.rd))
    else $error("read answer timing wrong");

  a_rdata_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !i_req.rd |=> $stable(o_rdata))
    else $error("read data moved without a read");

  // reset clears everything writable, checked while reset is applied
  a_rst_clear: assert property (@(posedge i_ref_clk)
    !i_rst_n |=> st_q.mode == 3'h0 && st_q.en == 2'h0 && st_q.tbl == '0 && !o_rvalid)
    else $error("reset left state behind");

  // main scenarios
  c_ctl_write: cover property (@(posedge i_ref_clk) i_req.wr && i_req.addr == `TPHCAP_OFF_CTL);
  c_tbl_read: cover property (@(posedge i_ref_clk) i_req.rd && tbl_hit[3]);
  c_tag_valid: cover property (@(posedge i_ref_clk) o_hint.tag_valid && o_hint.hint_enable);
  c_rsvd_en: cover property (@(posedge i_ref_clk) st_q.en == TPHCAP_EN_RSVD);
  c_mid_reset: cover property (@(posedge i_ref_clk) $fell(i_rst_n));

endmodule

//--- common/tphcap_defs.svh
`ifndef TPHCAP_DEFS_SVH
`define TPHCAP_DEFS_SVH

// byte offsets in configuration space, and the table word count
`define TPHCAP_OFF_HDR 12'h1a0
`define TPHCAP_OFF_CAP 12'h1a4
`define TPHCAP_OFF_CTL 12'h1a8
`define TPHCAP_OFF_TBL 12'h1ac
`define TPHCAP_TBL_WORDS 4

// header fields
`define TPHCAP_EXT_ID 16'h0017
`define TPHCAP_VERSION 4'h1
`define TPHCAP_NEXT_PTR 12'h01c

// capabilities fields
`define TPHCAP_NO_ST_BIT 0
`define TPHCAP_INTVEC_BIT 1
`define TPHCAP_DEVSPEC_BIT 2
`define TPHCAP_EXT_BIT 8
`define TPHCAP_LOC_LSB 9
`define TPHCAP_LOC_IN_CAP 2'h1
`define TPHCAP_SIZE_LSB 16
`define TPHCAP_TABLE_SIZE_M1 11'h007

// control fields
`define TPHCAP_MODE_LSB 0
`define TPHCAP_EN_LSB 8
`define TPHCAP_CTL_RESET 32'h0000_0000

// table entry positions
`define TPHCAP_ENT_LO_LSB 0
`define TPHCAP_ENT_HI_LSB 16

`endif

//--- common/tphcap_pkg.sv
package tphcap_pkg;

  typedef enum logic [2:0] {
    TPHCAP_MODE_NO_TABLE = 3'h0,
    TPHCAP_MODE_INT_VEC = 3'h1,
    TPHCAP_MODE_DEV_SPEC = 3'h2
  } tphcap_mode_t;

  typedef enum logic [1:0] {
    TPHCAP_EN_OFF = 2'h0,
    TPHCAP_EN_TPH = 2'h1,
    TPHCAP_EN_RSVD = 2'h2,
    TPHCAP_EN_TPH_EXT = 2'h3
  } tphcap_en_t;

  // configuration access request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } tphcap_req_t;

  // view handed to the request engine
  typedef struct packed {
    logic [2:0] mode;
    logic hint_enable;
    logic ext_enable;
    logic tag_valid;
    logic [7:0] tag;
  } tphcap_hint_t;

  typedef struct packed {
    logic [2:0] mode;
    logic [1:0] en;
    logic [15:0][7:0] unused_pad;
  } tphcap_unused_t;

endpackage

//--- tb/tphcap_regs_tb_top.sv
module tphcap_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import tphcap_pkg::*;

  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  tphcap_req_t i_req = '0;
  logic [2:0] i_tag_index = 3'h0;
  logic [31:0] o_rdata;
  logic o_rvalid;
  tphcap_hint_t o_hint;
  int err_count = 0;
  int cmp_count = 0;

  tphcap_regs #(.ENTRIES(8)) u_tphcap_regs (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_req(i_req),
    .o_rdata(o_rdata),
    .o_rvalid(o_rvalid),
    .i_tag_index(i_tag_index),
    .o_hint(o_hint)
  );

  always #2 i_ref_clk = ~i_ref_clk;

  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict;
    if (err_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic reg_wr(logic [11:0] a, logic [3:0] be, logic [31:0] d);
    @(posedge i_ref_clk);
    i_req <= '{wr: 1'b1, rd: 1'b0, addr: a, be: be, wdata: d};
    @(posedge i_ref_clk);
    i_req.wr <= 1'b0;
    #1;
  endtask

  // read answer comes one edge after the request edge; bounded wait guards a dead rvalid
  task automatic rd_chk(string nm, logic [11:0] a, logic [31:0] exp);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    i_req <= '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'h0, wdata: 32'h0};
    @(posedge i_ref_clk);
    i_req.rd <= 1'b0;
    #1;
    while (o_rvalid !== 1'b1 && n < 8) begin
      @(posedge i_ref_clk);
      #1;
      n++;
    end
    if (n == 8) begin
      err_count++;
      print_verdict();
    end
    check("rvalid", {31'h0, o_rvalid}, 32'h1);
    check(nm, o_rdata, exp);
  endtask

  initial begin
    repeat (5000) @(posedge i_ref_clk);
    err_count++;
    print_verdict();
  end

  initial begin
    repeat (20) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    check("hint_enable", {31'h0, o_hint.hint_enable}, 32'h0);
    rd_chk("header", 12'h1a0, 32'h01c10017);
    rd_chk("caps", 12'h1a4, 32'h00070205);
    rd_chk("control", 12'h1a8, 32'h0);
    for (int i = 0; i < 4; i++) rd_chk("table", 12'h1ac + 12'(4 * i), 32'h0);
    // read-only words must shrug off full writes
    reg_wr(12'h1a0, 4'hf, 32'hffffffff);
    reg_wr(12'h1a4, 4'hf, 32'hffffffff);
    rd_chk("header", 12'h1a0, 32'h01c10017);
    rd_chk("caps", 12'h1a4, 32'h00070205);
    reg_wr(12'h1a8, 4'hf, 32'hffffffff);
    rd_chk("control", 12'h1a8, 32'h00000307);
    check("ext_enable", {31'h0, o_hint.ext_enable}, 32'h0);
    reg_wr(12'h1a8, 4'h1, 32'h0);
    rd_chk("control", 12'h1a8, 32'h00000300);
    for (int e = 0; e < 4; e++) begin
      reg_wr(12'h1a8, 4'h3, {22'h0, 2'(e), 8'h02});
      check("hint_enable", {31'h0, o_hint.hint_enable}, 32'(e % 2));
      check("ext_enable", {31'h0, o_hint.ext_enable}, 32'h0);
      check("mode", {29'h0, o_hint.mode}, 32'h2);
    end
    // enable lane only: mode bits in the same word must be dropped
    reg_wr(12'h1a8, 4'h2, 32'h00000105);
    rd_chk("control", 12'h1a8, 32'h00000102);
    for (int i = 0; i < 4; i++) begin
      reg_wr(12'h1ac + 12'(4 * i), 4'hf, 32'hffffffff);
      rd_chk("table", 12'h1ac + 12'(4 * i), 32'h00ff00ff);
      reg_wr(12'h1ac + 12'(4 * i), 4'h5, {8'hff, 8'(34 * i + 17), 8'hff, 8'(34 * i)});
      reg_wr(12'h1ac + 12'(4 * i), 4'ha, 32'hffffffff);
      rd_chk("table", 12'h1ac + 12'(4 * i), {16'h0, 16'(34 * i + 17)} << 16 | 32'(34 * i));
    end
    // entry zero holds zero, so it must come out invalid
    for (int k = 0; k < 8; k++) begin
      @(posedge i_ref_clk);
      i_tag_index <= 3'(k);
      #1;
      check("tag", {24'h0, o_hint.tag}, 32'(17 * k));
      check("tag_valid", {31'h0, o_hint.tag_valid}, 32'(k != 0));
    end
    reg_wr(12'h1bc, 4'hf, 32'hffffffff);
    rd_chk("unmapped", 12'h1bc, 32'h0);
    @(posedge i_ref_clk);
    i_rst_n <= 1'b0;
    @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    rd_chk("control", 12'h1a8, 32'h0);
    rd_chk("table", 12'h1b0, 32'h0);
    print_verdict();
  end
endmodule
